// File: logic/acp_pkg.sv
package acp_pkg;
  // ==========================================================
  // clock and timebase
  localparam int              CLK_HZ         = 100_000_000;
  localparam int              TICK_S         = 1;
  localparam int              TICK_CYC_DFLT  = CLK_HZ * TICK_S;
  localparam int              BLINK_MS       = 500;
  localparam int              BLINK_CYC_DFLT = (CLK_HZ / 1000) * BLINK_MS;

  // ==========================================================
  // sequence times, in seconds
  localparam int              SEC_W          = 5;
  localparam logic [SEC_W-1:0] INHIBIT_S     = 5'h0f;
  localparam logic [SEC_W-1:0] FORCED_S      = 5'h0f;
  localparam logic [SEC_W-1:0] HP_DELAY_S    = 5'h0a;

  // ==========================================================
  // clutch cycle-rate limit
  localparam int              RATE_STARTS    = 4;
  localparam int              AGE_W          = 7;
  localparam logic [AGE_W-1:0] RATE_WIN_S    = 7'h3c;

  // ambient comparator threshold, degrees celsius
  localparam int              AMB_LIMIT_DEGC = -12;

  // ==========================================================
  // pressure switch as resolved by the analog front end
  typedef enum logic [1:0] {
    SW_CLOSED,
    SW_RESISTOR,
    SW_OPEN_CCT
  } acp_sw_t;

  // ==========================================================
  // red blink codes and indicator framing, in half-second slots
  localparam logic [2:0] CODE_NONE       = 3'h0;
  localparam logic [2:0] CODE_LOW        = 3'h1;
  localparam logic [2:0] CODE_HIGH       = 3'h2;
  localparam logic [2:0] CODE_CLUTCH     = 3'h3;
  localparam logic [2:0] CODE_WIRING     = 3'h4;
  localparam logic [3:0] GREEN_ON_SLOTS  = 4'h4;
  localparam logic [3:0] GREEN_FRAME     = 4'h5;
  localparam logic [3:0] RED_PAUSE_SLOTS = 4'h4;
endpackage : acp_pkg

// File: logic/acp_blink.sv
`timescale 1ns/100ps
module acp_blink #(
  parameter int BLINK_CYC = acp_pkg::BLINK_CYC_DFLT
) (
  input  wire logic       ref_clk_in,
  input  wire logic       arst_n_in,
  input  wire logic [2:0] code_in,
  output logic            red_led_out,
  output logic            green_led_out
);
  import acp_pkg::*;

  logic [31:0] pre_reg,   pre_next;
  logic [3:0]  slot_reg,  slot_next;
  logic        red_reg,   red_next;
  logic        green_reg, green_next;
  logic [3:0]  frame;
  logic        slot_tick;

  // ==========================================================
  // slot timebase and pattern
  always_comb begin
    slot_tick = (pre_reg == 32'(BLINK_CYC - 1));
    pre_next  = slot_tick ? 32'h0 : pre_reg + 32'h1;
    frame     = (code_in == CODE_NONE) ? GREEN_FRAME
                : {code_in, 1'b0} + RED_PAUSE_SLOTS;
    slot_next = slot_reg;
    // wrap on >= so a code change mid-frame cannot strand the slot
    if (slot_tick) begin
      slot_next = (slot_reg >= frame - 4'h1) ? 4'h0 : slot_reg + 4'h1;
    end
    red_next   = (code_in != CODE_NONE) && !slot_reg[0]
                 && (slot_reg < {code_in, 1'b0});
    green_next = (code_in == CODE_NONE)
                 && (slot_reg < GREEN_ON_SLOTS);
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pre_reg   <= 32'h0;
      slot_reg  <= 4'h0;
      red_reg   <= 1'b0;
      green_reg <= 1'b0;
    end else begin
      pre_reg   <= pre_next;
      slot_reg  <= slot_next;
      red_reg   <= red_next;
      green_reg <= green_next;
    end
  end

  assign red_led_out   = red_reg;
  assign green_led_out = green_reg;

  // ==========================================================
  // checks
  AST_RED_QUIET: assert property (@(posedge ref_clk_in)
    disable iff (!arst_n_in)
    code_in == CODE_NONE |=> !red_reg)
    else $error("red lit with no fault");
  AST_GREEN_DARK_ON_FAULT: assert property (@(posedge ref_clk_in)
    disable iff (!arst_n_in)
    code_in != CODE_NONE |=> !green_reg)
    else $error("green lit during a fault");
endmodule : acp_blink

// File: logic/acp_ctrl.sv
`timescale 1ns/100ps
module acp_ctrl #(
  parameter int TICK_CYC  = acp_pkg::TICK_CYC_DFLT,
  parameter int BLINK_CYC = acp_pkg::BLINK_CYC_DFLT
) (
  input  wire logic             ref_clk_in,
  input  wire logic             arst_n_in,
  input  wire logic             cool_req_in,
  input  wire logic             amb_above_limit_in,
  input  wire acp_pkg::acp_sw_t lp_state_in,
  input  wire acp_pkg::acp_sw_t hp_state_in,
  input  wire logic             clutch_fault_in,
  output logic                  comp_drive_out,
  output logic                  fan_req_out,
  output logic                  comp_disabled_out,
  output logic                  red_led_out,
  output logic                  green_led_out
);
  import acp_pkg::*;

  typedef enum logic [2:0] {
    ST_SAMPLE,
    ST_INHIBIT,
    ST_FORCED,
    ST_RUN,
    ST_OFF
  } acp_st_t;

  // ==========================================================
  // sequencer state
  acp_st_t           st_reg,     st_next;
  logic [31:0]       pre_reg,    pre_next;
  logic [SEC_W-1:0]  sec_reg,    sec_next;
  logic              tick;

  // high pressure timing
  logic [31:0]       hp_pre_reg, hp_pre_next;
  logic [SEC_W-1:0]  hp_sec_reg, hp_sec_next;
  logic              hp_lock_reg, hp_lock_next;
  logic              hp_tick;

  // drive and status
  logic              comp_reg,   comp_next;
  logic              fan_reg,    fan_next;
  logic              dis_reg,    dis_next;
  logic [2:0]        code_reg,   code_next;

  // start history, slot 0 newest
  logic [AGE_W-1:0]  age_reg  [RATE_STARTS];
  logic [AGE_W-1:0]  age_next [RATE_STARTS];
  logic [RATE_STARTS-1:0] vld_reg, vld_next, recent;

  logic lp_low, hp_high, wiring, block, want, rate_ok, start;

  // front end delivers resolved switch states
  assign lp_low  = (lp_state_in == SW_CLOSED);
  assign hp_high = (hp_state_in == SW_RESISTOR);
  assign wiring  = (lp_state_in == SW_OPEN_CCT)
                   || (hp_state_in == SW_OPEN_CCT);

  // ==========================================================
  // start-up sequence
  always_comb begin
    tick     = (pre_reg == 32'(TICK_CYC - 1));
    st_next  = st_reg;
    sec_next = sec_reg;
    case (st_reg)
      ST_SAMPLE: begin
        // comparator trips at the ambient limit
        st_next  = amb_above_limit_in ? ST_INHIBIT : ST_OFF;
        sec_next = '0;
      end
      ST_INHIBIT: begin
        if (tick) begin
          if (sec_reg == INHIBIT_S - 5'h01) begin
            st_next  = ST_FORCED;
            sec_next = '0;
          end else begin
            sec_next = sec_reg + 5'h01;
          end
        end
      end
      ST_FORCED: begin
        if (tick) begin
          if (sec_reg == FORCED_S - 5'h01) begin
            st_next  = ST_RUN;
            sec_next = '0;
          end else begin
            sec_next = sec_reg + 5'h01;
          end
        end
      end
      ST_RUN: begin
        st_next = ST_RUN;
      end
      ST_OFF: begin
        st_next = ST_OFF;
      end
      default: begin
        st_next = ST_SAMPLE;
      end
    endcase
    // restart the second timer on each step so phases are whole
    pre_next = (tick || st_next != st_reg) ? 32'h0 : pre_reg + 32'h1;
  end

  // ==========================================================
  // high pressure: fan request, 10 s grace, lockout
  always_comb begin
    hp_tick      = (hp_pre_reg == 32'(TICK_CYC - 1));
    hp_pre_next  = 32'h0;
    hp_sec_next  = '0;
    hp_lock_next = hp_lock_reg;
    fan_next     = hp_high;
    if (hp_high) begin
      hp_pre_next = hp_tick ? 32'h0 : hp_pre_reg + 32'h1;
      hp_sec_next = hp_sec_reg;
      if (hp_tick && hp_sec_reg != HP_DELAY_S) begin
        hp_sec_next = hp_sec_reg + 5'h01;
      end
      if (hp_tick && hp_sec_reg == HP_DELAY_S - 5'h01) begin
        hp_lock_next = 1'b1;
      end
    end else if (hp_state_in == SW_CLOSED) begin
      hp_lock_next = 1'b0;
    end
  end

  // ==========================================================
  // start history; a slot counts until its age passes the window
  generate
    for (genvar i = 0; i < RATE_STARTS; i++) begin : g_slot
      assign recent[i] = vld_reg[i] && (age_reg[i] <= RATE_WIN_S);
      always_comb begin
        age_next[i] = age_reg[i];
        vld_next[i] = vld_reg[i];
        if (start) begin
          if (i == 0) begin
            age_next[i] = '0;
            vld_next[i] = 1'b1;
          end else begin
            age_next[i] = age_reg[(i == 0) ? 0 : i - 1];
            vld_next[i] = vld_reg[(i == 0) ? 0 : i - 1];
          end
        end else if (tick && recent[i]) begin
          age_next[i] = age_reg[i] + 7'h01;
        end
      end
    end
  endgenerate

  // ==========================================================
  // compressor drive and fault code
  always_comb begin
    rate_ok = !recent[RATE_STARTS-1];
    block   = lp_low || wiring || hp_lock_reg;
    want    = (st_reg == ST_FORCED)
              || (st_reg == ST_RUN && cool_req_in);
    // no fresh start while high side is still open
    start   = !comp_reg && want && !block && !hp_high && rate_ok;
    comp_next = comp_reg ? (want && !block) : start;
    dis_next  = (st_reg == ST_OFF);
    if (wiring) begin
      code_next = CODE_WIRING;
    end else if (lp_low) begin
      code_next = CODE_LOW;
    end else if (hp_high || hp_lock_reg) begin
      code_next = CODE_HIGH;
    end else if (clutch_fault_in) begin
      code_next = CODE_CLUTCH;
    end else begin
      code_next = CODE_NONE;
    end
  end

  // ignition-on is the reset: every timer and history cleared
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_reg      <= ST_SAMPLE;
      pre_reg     <= 32'h0;
      sec_reg     <= '0;
      hp_pre_reg  <= 32'h0;
      hp_sec_reg  <= '0;
      hp_lock_reg <= 1'b0;
      comp_reg    <= 1'b0;
      fan_reg     <= 1'b0;
      dis_reg     <= 1'b0;
      code_reg    <= CODE_NONE;
      vld_reg     <= '0;
      for (int k = 0; k < RATE_STARTS; k++) begin
        age_reg[k] <= '0;
      end
    end else begin
      st_reg      <= st_next;
      pre_reg     <= pre_next;
      sec_reg     <= sec_next;
      hp_pre_reg  <= hp_pre_next;
      hp_sec_reg  <= hp_sec_next;
      hp_lock_reg <= hp_lock_next;
      comp_reg    <= comp_next;
      fan_reg     <= fan_next;
      dis_reg     <= dis_next;
      code_reg    <= code_next;
      vld_reg     <= vld_next;
      for (int k = 0; k < RATE_STARTS; k++) begin
        age_reg[k] <= age_next[k];
      end
    end
  end

  assign comp_drive_out    = comp_reg;
  assign fan_req_out       = fan_reg;
  assign comp_disabled_out = dis_reg;

  acp_blink #(
    .BLINK_CYC     (BLINK_CYC)
  ) u_blink (
    .ref_clk_in    (ref_clk_in),
    .arst_n_in     (arst_n_in),
    .code_in       (code_reg),
    .red_led_out   (red_led_out),
    .green_led_out (green_led_out)
  );

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);

  AST_INHIBIT_OFF: assert property (
    st_reg == ST_INHIBIT |=> !comp_drive_out)
    else $error("compressor on during start-up inhibit");
  AST_FORCED_ON: assert property (
    st_reg == ST_FORCED && !block && !hp_high && rate_ok
    |=> comp_drive_out)
    else $error("forced run did not drive compressor");
  AST_COLD_OFF: assert property (
    dis_reg |-> !comp_drive_out && st_reg == ST_OFF)
    else $error("compressor on below ambient limit");
  // wiring outranks low pressure in the fault code
  AST_LOW_OFF: assert property (
    lp_state_in == SW_CLOSED && hp_state_in != SW_OPEN_CCT
    |=> !comp_drive_out && code_reg == CODE_LOW)
    else $error("low pressure left compressor on");
  AST_HIGH_FAN: assert property (
    hp_state_in == SW_RESISTOR |=> fan_req_out)
    else $error("fan request missing on high pressure");
  AST_HP_LOCK: assert property (
    $rose(hp_lock_reg) |-> $past(hp_sec_reg) == HP_DELAY_S - 5'h01
    ##1 !comp_drive_out)
    else $error("high pressure lockout timing wrong");
  AST_HP_HOLD: assert property (
    hp_lock_reg |=> !comp_drive_out)
    else $error("compressor on during high pressure lockout");
  AST_RATE: assert property (
    $rose(comp_drive_out) |-> !$past(recent[RATE_STARTS-1]))
    else $error("start beyond cycle-rate limit");
  AST_WIRING: assert property (
    wiring |=> code_reg == CODE_WIRING && !comp_drive_out)
    else $error("open circuit not flagged");
  AST_THERMO: assert property (
    st_reg == ST_RUN && !cool_req_in |=> !comp_drive_out)
    else $error("compressor on without request");

  COV_FORCED: cover property ($rose(st_reg == ST_RUN));
  COV_LOCK: cover property ($rose(hp_lock_reg));
  COV_RATE_HOLD: cover property (
    st_reg == ST_RUN && cool_req_in && !block && !hp_high && !rate_ok);
  COV_COLD: cover property ($rose(dis_reg));
endmodule : acp_ctrl

// File: bench/acp_plant.sv
`timescale 1ns/100ps
// ==========================================================
// far side: thermostat, switches, clutch circuit, fan timer
module acp_plant #(
  parameter int FAN_HOLD = 50
) (
  input  wire logic        ref_clk_in,
  input  wire logic        fan_req_in,
  output logic             cool_req_out,
  output logic             amb_above_limit_out,
  output acp_pkg::acp_sw_t lp_state_out,
  output acp_pkg::acp_sw_t hp_state_out,
  output logic             clutch_fault_out,
  output logic             fan_run_out
);
  import acp_pkg::*;
  int fan_cnt = 0;

  // levels changed by the bench only just after a falling edge
  initial begin
    cool_req_out        = 1'b1;
    amb_above_limit_out = 1'b1;
    lp_state_out        = SW_RESISTOR;
    hp_state_out        = SW_CLOSED;
    clutch_fault_out    = 1'b0;
  end

  // ==========================================================
  // fan timer: request only retriggers, run length is ours
  always @(posedge ref_clk_in) begin
    if (fan_req_in === 1'b1) begin
      fan_cnt <= FAN_HOLD;
    end else if (fan_cnt > 0) begin
      fan_cnt <= fan_cnt - 1;
    end
  end
  assign fan_run_out = (fan_cnt > 0);
endmodule : acp_plant

// File: bench/testbench.sv
`timescale 1ns/100ps
module testbench;
  import acp_pkg::*;
  // short ticks keep the 60 s window near 600 cycles
  localparam int TICK = 10;
  localparam int BLNK = 4;
  logic    ref_clk_in = 1'b0;
  logic    arst_n_in  = 1'b0;
  logic    cool_req, amb_above, clutch_fault, fan_run;
  logic    comp_drive, fan_req, comp_dis, red_led, green_led;
  acp_sw_t lp_state, hp_state;
  int      errors     = 0;
  int      num_checks = 0;
  int      cyc        = 0;
  int      wd         = 0;

  always #5 ref_clk_in = ~ref_clk_in;

  acp_ctrl #(.TICK_CYC(TICK), .BLINK_CYC(BLNK)) dut (
    .ref_clk_in        (ref_clk_in),
    .arst_n_in         (arst_n_in),
    .cool_req_in       (cool_req),
    .amb_above_limit_in(amb_above),
    .lp_state_in       (lp_state),
    .hp_state_in       (hp_state),
    .clutch_fault_in   (clutch_fault),
    .comp_drive_out    (comp_drive),
    .fan_req_out       (fan_req),
    .comp_disabled_out (comp_dis),
    .red_led_out       (red_led),
    .green_led_out     (green_led)
  );

  acp_plant pl (
    .ref_clk_in         (ref_clk_in),
    .fan_req_in         (fan_req),
    .cool_req_out       (cool_req),
    .amb_above_limit_out(amb_above),
    .lp_state_out       (lp_state),
    .hp_state_out       (hp_state),
    .clutch_fault_out   (clutch_fault),
    .fan_run_out        (fan_run)
  );

  // ==========================================================
  // cycle count since release, and a hang limit
  always @(posedge ref_clk_in) begin
    cyc <= arst_n_in ? cyc + 1 : 0;
    wd  <= wd + 1;
    if (wd == 3000) begin
      errors++;
      complete_run();
    end
  end

  task automatic at(input int c);
    while (cyc < c) @(negedge ref_clk_in);
  endtask : at

  task automatic chk(input logic got, input logic exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask : chk

  // whole frames only, so the blink phase does not matter
  task automatic leds(input int n, input int exp_r, input int exp_g);
    int r;
    int g;
    r = 0;
    g = 0;
    repeat (n) begin
      @(negedge ref_clk_in);
      // an unknown level counts as lit so it cannot slip past
      if (red_led !== 1'b0) r++;
      if (green_led !== 1'b0) g++;
    end
    num_checks++;
    if (r != exp_r || (exp_g >= 0 && g != exp_g)) begin
      errors++;
      $display("CHECK FAILED %0t lit counts %0d %0d", $time, r, g);
    end
  endtask : leds

  task automatic restart(input logic amb);
    @(negedge ref_clk_in);
    arst_n_in = 1'b0;
    pl.amb_above_limit_out = amb;
    repeat (2) @(negedge ref_clk_in);
    chk(comp_drive, 1'b0, "drive in reset");
    chk(red_led, 1'b0, "red in reset");
    arst_n_in = 1'b1;
  endtask : restart

  task automatic complete_run();
    if (errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run

  // ==========================================================
  // main sequence
  initial begin
    repeat (2) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    arst_n_in = 1'b1;
    at(145); chk(comp_drive, 1'b0, "inhibit");
    chk(comp_dis, 1'b0, "warm ambient");
    pl.cool_req_out = 1'b0;
    at(160); chk(comp_drive, 1'b1, "forced on");
    at(290); chk(comp_drive, 1'b1, "forced held");
    at(310); chk(comp_drive, 1'b0, "no request");
    pl.cool_req_out = 1'b1;
    at(320); chk(comp_drive, 1'b1, "request");
    leds(40, 0, 32);
    at(362); pl.lp_state_out = SW_CLOSED;
    at(366); chk(comp_drive, 1'b0, "low pressure");
    at(392); leds(48, 8, -1);
    pl.lp_state_out = SW_RESISTOR;
    at(446); chk(comp_drive, 1'b1, "low cleared");
    at(450); pl.hp_state_out = SW_RESISTOR;
    at(453); chk(fan_req, 1'b1, "fan request");
    at(480); leds(64, 16, -1);
    at(545); chk(comp_drive, 1'b1, "high grace");
    at(556); chk(comp_drive, 1'b0, "high stop");
    at(580); chk(comp_drive, 1'b0, "lock held");
    pl.hp_state_out = SW_CLOSED;
    at(586); chk(comp_drive, 1'b1, "high cleared");
    chk(fan_req, 1'b0, "fan released");
    chk(fan_run, 1'b1, "fan timer holds");
    at(600); pl.cool_req_out = 1'b0;
    at(610); pl.cool_req_out = 1'b1;
    at(620); chk(comp_drive, 1'b0, "fifth start");
    at(740); chk(comp_drive, 1'b0, "window held");
    chk(fan_run, 1'b0, "fan timer ran out");
    at(800); chk(comp_drive, 1'b1, "window aged");
    at(810); pl.hp_state_out = SW_OPEN_CCT;
    at(815); chk(comp_drive, 1'b0, "open wiring");
    at(870); leds(96, 32, -1);
    pl.hp_state_out = SW_CLOSED;
    pl.clutch_fault_out = 1'b1;
    at(1020); leds(80, 24, -1);
    pl.clutch_fault_out = 1'b0;
    restart(1'b0);
    // warming after the sample must not reopen the sequence
    at(10); pl.amb_above_limit_out = 1'b1;
    at(400); chk(comp_drive, 1'b0, "cold ambient");
    chk(comp_dis, 1'b1, "cold latched");
    restart(1'b1);
    at(145); chk(comp_drive, 1'b0, "inhibit again");
    chk(comp_dis, 1'b0, "latch cleared");
    at(160); chk(comp_drive, 1'b1, "history cleared");
    complete_run();
  end
endmodule : testbench
